// ---- rtl/crb_buffer.sv ----
`timescale 1ns/1ps
`default_nettype none

module crb_buffer #(
   parameter int DATA_W = crb_pkg::DATA_W,
   parameter int HALF_W = crb_pkg::HALF_W
) (
   input  wire logic                      CLK_SYS,
   input  wire logic                      RST,
   input  wire logic                      RESET_N,
   input  wire logic [crb_pkg::DATA_W-1:0] D_IN,
   input  wire logic                      DATA_CHIP_SELECT_N,
   input  wire logic                      REDUNDANT_CHIP_SELECT_N,
   input  wire logic                      PARITY_IN,
   input  wire logic                      PAIR_SELECT,
   input  wire logic                      FANOUT_SELECT,
   input  wire logic                      CASCADE_FIRST,
   output var  logic [crb_pkg::DATA_W-1:0] Q_A,
   output var  logic [crb_pkg::HALF_W-1:0] Q_B,
   output var  logic                      CHIP_SELECT_OUT,
   output var  logic                      PARTIAL_PARITY_OUT,
   output var  logic                      PARITY_ERROR_N,
   output var  logic                      PARITY_ERROR_N_OE
);
   import crb_pkg::*;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [24:0] cover_mask(input logic pair, input logic fanout);
      logic [24:0] m;
      m = MASK_ONE_TO_ONE;
      if (fanout) begin
         m = pair ? MASK_PAIR_B : MASK_PAIR_A;
      end
      return m;
   endfunction : cover_mask

   logic [DATA_W-1:0] qa_q, qa_d;
   logic [HALF_W-1:0] qb_q, qb_d;
   logic              cs_q, cs_d;
   logic              par1_q, par1_d;
   logic              par2_q, par2_d;
   logic              ppo_q, ppo_d;
   logic              err_n_q, err_n_d;
   logic              oe_q, oe_d;
   crb_err_t          err_st_q, err_st_d;
   logic              upd_en;
   logic              ppo_calc;

   // Gating only when both selects are high
   assign upd_en   = !(DATA_CHIP_SELECT_N && REDUNDANT_CHIP_SELECT_N);
   // Two-cycle lag costs one extra flop, kept always running
   assign ppo_calc = (PAIR_SELECT ? par2_q : par1_q) ^ PARITY_IN;

   // ------------------------------------------------------------
   // Data path
   // ------------------------------------------------------------
   always_comb begin
      qa_d   = qa_q;
      qb_d   = qb_q;
      cs_d   = DATA_CHIP_SELECT_N;
      par1_d = ^(D_IN & cover_mask(PAIR_SELECT, FANOUT_SELECT));
      par2_d = par1_q;
      if (RST) begin
         qa_d   = '0;
         qb_d   = '0;
         cs_d   = RST_CS;
         par1_d = 1'b0;
         par2_d = 1'b0;
      end else if (upd_en) begin
         if (FANOUT_SELECT) begin
            qa_d = {{(DATA_W-HALF_W){1'b0}}, D_IN[HALF_W-1:0]};
            qb_d = D_IN[HALF_W-1:0];
         end else begin
            qa_d = D_IN;
            qb_d = '0;
         end
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         qa_q   <= '0;
         qb_q   <= '0;
         cs_q   <= RST_CS;
         par1_q <= 1'b0;
         par2_q <= 1'b0;
      end else begin
         qa_q   <= qa_d;
         qb_q   <= qb_d;
         cs_q   <= cs_d;
         par1_q <= par1_d;
         par2_q <= par2_d;
      end
   end

   // ------------------------------------------------------------
   // Parity check and error hold
   // ------------------------------------------------------------
   always_comb begin
      ppo_d    = ppo_q;
      err_st_d = err_st_q;
      oe_d     = !CASCADE_FIRST;
      if (RST) begin
         ppo_d    = RST_PPO;
         err_st_d = ERR_IDLE;
      end else if (upd_en) begin
         ppo_d = ppo_calc;
         case (err_st_q)
            ERR_IDLE:  err_st_d = ppo_calc ? ERR_LOW_1 : ERR_IDLE;
            ERR_LOW_1: err_st_d = ppo_calc ? ERR_LOW_1 : ERR_LOW_2;
            ERR_LOW_2: err_st_d = ppo_calc ? ERR_LOW_1 : ERR_IDLE;
            default:   err_st_d = ERR_IDLE;
         endcase
      end else begin
         // Gated cycles still age a held error
         case (err_st_q)
            ERR_LOW_1: err_st_d = ERR_LOW_2;
            ERR_LOW_2: err_st_d = ERR_IDLE;
            default:   err_st_d = err_st_q;
         endcase
      end
      err_n_d = (err_st_d == ERR_IDLE);
   end

   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         ppo_q    <= RST_PPO;
         err_st_q <= ERR_IDLE;
         err_n_q  <= RST_ERR_N;
         oe_q     <= 1'b0;
      end else begin
         ppo_q    <= ppo_d;
         err_st_q <= err_st_d;
         err_n_q  <= err_n_d;
         oe_q     <= oe_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // Straight from flops, so a quiet release cannot glitch
   assign Q_A                = qa_q;
   assign Q_B                = qb_q;
   assign CHIP_SELECT_OUT    = cs_q;
   assign PARTIAL_PARITY_OUT = ppo_q;
   assign PARITY_ERROR_N     = err_n_q;
   assign PARITY_ERROR_N_OE  = oe_q;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   chk_capture_one_one: assert property (@(posedge CLK_SYS) disable iff (RST || !RESET_N)
      (!FANOUT_SELECT && upd_en) |=> (Q_A == $past(D_IN)))
      else $error("1:1 capture mismatch");

   chk_dup_fanout: assert property (@(posedge CLK_SYS) disable iff (RST || !RESET_N)
      (FANOUT_SELECT && upd_en) |=> (Q_B == Q_A[HALF_W-1:0]) && (Q_A[DATA_W-1:HALF_W] == '0))
      else $error("1:2 outputs not duplicated");

   chk_gate_hold: assert property (@(posedge CLK_SYS) disable iff (RST || !RESET_N)
      (DATA_CHIP_SELECT_N && REDUNDANT_CHIP_SELECT_N) |=> $stable(Q_A) && $stable(Q_B))
      else $error("gated outputs changed");

   chk_cs_follow: assert property (@(posedge CLK_SYS) disable iff (RST || !RESET_N)
      1'b1 |=> (CHIP_SELECT_OUT == $past(DATA_CHIP_SELECT_N)))
      else $error("chip select output did not follow");

   chk_err_two_cycles: assert property (@(posedge CLK_SYS) disable iff (RST || !RESET_N)
      $fell(PARITY_ERROR_N) |-> !PARITY_ERROR_N ##1 !PARITY_ERROR_N)
      else $error("error flag not held two cycles");

   chk_err_release: assert property (@(posedge CLK_SYS) disable iff (RST || !RESET_N)
      (!PARITY_ERROR_N && !(upd_en && ppo_calc)) ##1 (!PARITY_ERROR_N && !(upd_en && ppo_calc))
      |=> PARITY_ERROR_N)
      else $error("error flag held too long");

   chk_ppo_lag: assert property (@(posedge CLK_SYS) disable iff (RST || !RESET_N)
      (upd_en && PAIR_SELECT && !$past(RST) && !$past(RST, 2) && $past(RESET_N)
         && $past(RESET_N, 2))
      |=> PARTIAL_PARITY_OUT == (^($past(D_IN, 3) & cover_mask(PAIR_SELECT, FANOUT_SELECT))
                                 ^ $past(PARITY_IN)))
      else $error("two-cycle parity lag wrong");

   chk_ppo_lag_one: assert property (@(posedge CLK_SYS) disable iff (RST || !RESET_N)
      (upd_en && !PAIR_SELECT && !$past(RST) && $past(RESET_N))
      |=> PARTIAL_PARITY_OUT == (^($past(D_IN, 2) & cover_mask(PAIR_SELECT, FANOUT_SELECT))
                                 ^ $past(PARITY_IN)))
      else $error("one-cycle parity lag wrong");

   chk_ppo_err: assert property (@(posedge CLK_SYS) disable iff (RST || !RESET_N)
      (upd_en && ppo_calc) |=> (PARTIAL_PARITY_OUT && !PARITY_ERROR_N))
      else $error("odd parity not flagged");

   chk_sync_clear: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      RST |=> (Q_A == '0) && !CHIP_SELECT_OUT && !PARTIAL_PARITY_OUT && PARITY_ERROR_N)
      else $error("reset did not clear outputs");

   chk_release_quiet: assert property (@(posedge CLK_SYS) disable iff (RST || !RESET_N)
      (!$past(RESET_N) && (D_IN == '0)) |=> (Q_A == '0) && (Q_B == '0))
      else $error("outputs moved after reset release");

   chk_first_undriven: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      CASCADE_FIRST |=> !PARITY_ERROR_N_OE)
      else $error("first device drives error");

endmodule : crb_buffer

`default_nettype wire

// ---- rtl/crb_pkg.sv ----
`default_nettype none
package crb_pkg;

   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int DATA_W = 25;
   localparam int HALF_W = 14;

   // ------------------------------------------------------------
   // Parity coverage, bit i is data input i+1
   // ------------------------------------------------------------
   localparam logic [24:0] MASK_ONE_TO_ONE = 25'h1FFFFB6;
   localparam logic [24:0] MASK_PAIR_A     = 25'h0003FB6;
   localparam logic [24:0] MASK_PAIR_B     = 25'h0001BBF;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic RST_PPO   = 1'b0;
   localparam logic RST_ERR_N = 1'b1;
   localparam logic RST_CS    = 1'b0;

   // ------------------------------------------------------------
   // Error flag hold, in clock cycles
   // ------------------------------------------------------------
   localparam int ERR_HOLD_CYCLES = 2;

   typedef enum logic [2:0] {
      ERR_IDLE  = 3'b001,
      ERR_LOW_1 = 3'b010,
      ERR_LOW_2 = 3'b100
   } crb_err_t;

endpackage : crb_pkg
`default_nettype wire

// ---- test/crb_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// --------------------------------
// Controller side parity source
// --------------------------------
module crb_ctrl_model (
   input  wire logic        clk,
   input  wire logic [24:0] d,
   input  wire logic [24:0] mask,
   input  wire logic        pair,
   input  wire logic        flip,
   output var  logic        par
);
   logic p1;
   initial begin
      par = 1'b0;
      p1 = 1'b0;
   end
   // Word seen here was captured one edge ago
   always @(negedge clk) begin
      par <= (pair ? p1 : ^(d & mask)) ^ flip;
      p1 <= ^(d & mask);
   end
endmodule : crb_ctrl_model
`default_nettype wire

// ---- test/crb_buffer_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module crb_buffer_tb;
   import crb_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        rst_n = 1'b0;
   logic        data_chip_select_n = 1'b0, redundant_chip_select_n = 1'b0, fan = 1'b0, pair = 1'b0;
   logic        first = 1'b0, flip = 1'b0;
   logic [24:0] d = 25'h0000000, mask, qa;
   logic [13:0] qb;
   logic        chip_select_out, partial_parity_out, err_n, oe, par;
   int          n_errors = 0, total_checks = 0;
   assign mask = fan ? (pair ? MASK_PAIR_B : MASK_PAIR_A) : MASK_ONE_TO_ONE;
   always #2.5 clk = ~clk;
   crb_buffer dut (.CLK_SYS(clk), .RST(rst), .RESET_N(rst_n), .D_IN(d),
      .DATA_CHIP_SELECT_N(data_chip_select_n), .REDUNDANT_CHIP_SELECT_N(redundant_chip_select_n), .PARITY_IN(par),
      .PAIR_SELECT(pair), .FANOUT_SELECT(fan), .CASCADE_FIRST(first), .Q_A(qa),
      .Q_B(qb), .CHIP_SELECT_OUT(chip_select_out), .PARTIAL_PARITY_OUT(partial_parity_out),
      .PARITY_ERROR_N(err_n), .PARITY_ERROR_N_OE(oe));
   crb_ctrl_model ctrl (.clk(clk), .d(d), .mask(mask), .pair(pair), .flip(flip),
      .par(par));
   // --------------------------------
   // Access and compare tasks
   // --------------------------------
   task automatic cmp_v(input logic [24:0] got, input logic [24:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %0t word %h exp %h", $time, got, exp);
      end
   endtask : cmp_v
   task automatic cmp_b(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %0t flag %b exp %b", $time, got, exp);
      end
   endtask : cmp_b
   task automatic step(input logic [24:0] w, input logic ds, input logic cr);
      @(negedge clk);
      d <= w;
      data_chip_select_n <= ds;
      redundant_chip_select_n <= cr;
      @(posedge clk);
      #1;
      flip = 1'b0;
   endtask : step
   // Fan-out and pair select pins only move under reset
   task automatic set_mode(input logic f, input logic p);
      @(negedge clk);
      rst <= 1'b1;
      fan <= f;
      pair <= p;
      d <= 25'h0000000;
      @(negedge clk);
      rst <= 1'b0;
   endtask : set_mode
   task automatic give_verdict;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : give_verdict
   initial begin
      #20000;
      n_errors++;
      give_verdict();
   end
   // --------------------------------
   // Tests
   // --------------------------------
   initial begin
      logic [24:0] words [4] = '{25'h1FFFFFF, 25'h0000049, 25'h1555555, 25'h0AAAAAA};
      repeat (8) @(posedge clk);
      #1;
      cmp_v(qa, 25'h0000000);
      cmp_b(err_n, 1'b1);
      @(negedge clk);
      rst_n <= 1'b1;
      rst <= 1'b0;
      foreach (words[i]) begin
         step(words[i], 1'b0, 1'b0);
         cmp_v(qa, words[i]);
         cmp_v({11'h000, qb}, 25'h0000000);
         cmp_b(chip_select_out, 1'b0);
         cmp_b(partial_parity_out, 1'b0);
         cmp_b(err_n, 1'b1);
         cmp_b(oe, 1'b1);
      end
      $display("test one_to_one done");
      for (int m = 0; m < 3; m++) begin
         set_mode(m > 0, m == 2);
         step(25'h1FFFFFF, 1'b0, 1'b0);
         if (m > 0) begin
            cmp_v(qa, 25'h0003FFF);
            cmp_v({11'h000, qb}, 25'h0003FFF);
         end
         step(25'h0000002, 1'b0, 1'b0);
         if (m == 2)
            step(25'h0000000, 1'b0, 1'b0);
         flip = 1'b1;
         step(25'h0000000, 1'b0, 1'b0);
         cmp_b(partial_parity_out, 1'b1);
         cmp_b(err_n, 1'b0);
         step(25'h0000000, 1'b0, 1'b0);
         cmp_b(err_n, 1'b0);
         step(25'h0000000, 1'b0, 1'b0);
         cmp_b(err_n, 1'b1);
         cmp_b(partial_parity_out, 1'b0);
      end
      // Reset cuts a held error short
      flip = 1'b1;
      step(25'h0000000, 1'b0, 1'b0);
      cmp_b(err_n, 1'b0);
      set_mode(1'b0, 1'b0);
      cmp_b(err_n, 1'b1);
      $display("test parity done");
      step(25'h1FFFFFF, 1'b0, 1'b0);
      step(25'h0000000, 1'b1, 1'b1);
      cmp_v(qa, 25'h1FFFFFF);
      cmp_b(chip_select_out, 1'b1);
      step(25'h0000000, 1'b1, 1'b0);
      cmp_v(qa, 25'h0000000);
      step(25'h1FFFFFF, 1'b0, 1'b1);
      cmp_v(qa, 25'h1FFFFFF);
      @(negedge clk);
      first <= 1'b1;
      step(25'h1FFFFFF, 1'b1, 1'b1);
      cmp_b(oe, 1'b0);
      @(negedge clk);
      rst_n <= 1'b0;
      #1;
      cmp_v(qa, 25'h0000000);
      cmp_b(chip_select_out, 1'b0);
      cmp_b(err_n, 1'b1);
      step(25'h0000000, 1'b0, 1'b0);
      @(negedge clk);
      rst_n <= 1'b1;
      step(25'h0000000, 1'b0, 1'b0);
      cmp_v(qa, 25'h0000000);
      cmp_b(partial_parity_out, 1'b0);
      $display("test gating and reset done");
      give_verdict();
   end
endmodule : crb_buffer_tb
`default_nettype wire
